// ==== shared/lsu_pkg.sv ====
/*
 * Constants and types for the linear scaling unit: operation codes, divider
 * sizing, rounding divisor, saturation limits and special result codes.
 * Assumes the issuing logic and the unit share one clock.
 */
package lsu_pkg;
   typedef enum logic {
      LSU_OP_RATE_OFFSET,
      LSU_OP_INTERPOLATE
   } lsu_op_t;

   // rate-offset scaling divides the product by this figure
   localparam logic [32:0] LSU_SCALE_DIVISOR = 33'h000002710;
   // restoring divider width and step count
   localparam int LSU_NUM_W = 66;
   localparam logic [6:0] LSU_DIV_STEPS = 7'h42;
   localparam logic [6:0] LSU_CNT_RESET = 7'h00;

   localparam logic [31:0] LSU_NEG_NAN = 32'hFFFFFFFF;
   localparam logic [31:0] LSU_NEG_OVF = 32'h80000000;
   localparam logic [31:0] LSU_RESULT_RESET = 32'h00000000;
   localparam logic signed [67:0] LSU_LONG_MAX = 68'sh0_0000_0000_7FFF_FFFF;
   localparam logic signed [67:0] LSU_LONG_MIN = -68'sh0_0000_0000_8000_0000;
   localparam logic signed [67:0] LSU_WORD_MAX = 68'sh0_0000_0000_0000_7FFF;
   localparam logic signed [67:0] LSU_WORD_MIN = -68'sh0_0000_0000_0000_8000;

   // single precision field layout
   localparam logic [7:0] LSU_EXP_SPECIAL = 8'hFF;
   localparam logic [7:0] LSU_EXP_BIAS = 8'h7F;
   localparam logic [7:0] LSU_EXP_INT_LSB = 8'h96;
   localparam logic [7:0] LSU_EXP_INT_OVF = 8'h9E;
endpackage : lsu_pkg

// ==== verilog/lsu_scaler.sv ====
/*
 * Linear scaling unit: rate-offset scaling on 16-bit integer operands and two-point
 * interpolation on integer or single precision operands, one shared sequential divider.
 * Assumes operands are valid in the START cycle, where they are sampled, and that
 * START is a one-cycle pulse from logic on the same clock, issued only while idle.
 */
module lsu_scaler (
   // clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // request
   input wire logic START,
   input wire logic RUNG_TRUE,
   input wire lsu_pkg::lsu_op_t OP_SEL,
   input wire logic FLOAT_MODE,
   // rate-offset operands
   input wire logic [15:0] SRC_WORD,
   input wire logic [15:0] RATE,
   input wire logic [15:0] OFFSET,
   // interpolation operands
   input wire logic [31:0] IN_X,
   input wire logic [31:0] IN_X0,
   input wire logic [31:0] IN_X1,
   input wire logic [31:0] SCALED_Y0,
   input wire logic [31:0] SCALED_Y1,
   // answer
   output logic BUSY,
   output logic DONE,
   output logic DEST_WE,
   output logic [31:0] DEST_DATA,
   output logic OVERFLOW
);
   import lsu_pkg::*;

   typedef enum logic [1:0] {
      LSU_IDLE,
      LSU_DIVIDE,
      LSU_FINISH
   } lsu_state_t;

   // float to integer, truncating; flags values outside 32-bit range
   function automatic logic [33:0] lsu_f2i(input logic [31:0] f);
      logic [63:0] mag;
      logic [7:0] e;
      logic [33:0] r;
      e = f[30:23];
      mag = {40'h0000000000, 1'b1, f[22:0]};
      r = 34'h000000000;
      if (e >= LSU_EXP_INT_OVF) begin
         r[33] = 1'b1;
      end else if (e >= LSU_EXP_BIAS) begin
         if (e >= LSU_EXP_INT_LSB) begin
            mag = mag << (e - LSU_EXP_INT_LSB);
         end else begin
            mag = mag >> (LSU_EXP_INT_LSB - e);
         end
         r[32:0] = f[31] ? 33'(-$signed({1'b0, mag[31:0]})) : {1'b0, mag[31:0]};
      end
      return r;
   endfunction : lsu_f2i

   // signed 32-bit integer to float, truncating low bits
   function automatic logic [31:0] lsu_i2f(input logic [31:0] v);
      logic [31:0] mag;
      logic [31:0] norm;
      logic [7:0] msb;
      mag = v[31] ? 32'(-v) : v;
      msb = 8'h00;
      for (int i = 0; i < 32; i++) begin
         if (mag[i]) begin
            msb = 8'(i);
         end
      end
      norm = mag << (8'h1F - msb);
      if (mag == 32'h00000000) begin
         return 32'h00000000;
      end
      return {v[31], 8'(LSU_EXP_BIAS + msb), norm[30:8]};
   endfunction : lsu_i2f

   function automatic logic lsu_bad_float(input logic [31:0] f);
      return (f[30:23] == LSU_EXP_SPECIAL) || (f[30:23] == 8'h00 && f[22:0] != 23'h000000);
   endfunction : lsu_bad_float

   lsu_state_t state_q, state_d;
   logic [LSU_NUM_W-1:0] num_q, num_d;
   logic [33:0] rem_q, rem_d;
   logic [32:0] den_q, den_d;
   logic neg_q, neg_d;
   logic signed [32:0] addend_q, addend_d;
   logic op_q, op_d;
   logic flt_q, flt_d;
   logic [6:0] cnt_q, cnt_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic we_q, we_d;
   logic [31:0] data_q, data_d;
   logic ovf_q, ovf_d;

   always_comb begin
      logic [33:0] fx, fx0, fx1, fy0, fy1;
      logic signed [32:0] x, x0, x1, y0, y1, dy, dx, dxi;
      logic signed [65:0] prod;
      logic signed [31:0] sprod;
      logic bad, cvt_ovf;
      logic [34:0] trial;
      logic [LSU_NUM_W:0] q;
      logic signed [67:0] qs, sum;
      logic [31:0] clamped;
      clamped = 32'h00000000;
      state_d = state_q;
      num_d = num_q;
      rem_d = rem_q;
      den_d = den_q;
      neg_d = neg_q;
      addend_d = addend_q;
      op_d = op_q;
      flt_d = flt_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      we_d = 1'b0;
      data_d = data_q;
      ovf_d = ovf_q;
      fx = lsu_f2i(IN_X);
      fx0 = lsu_f2i(IN_X0);
      fx1 = lsu_f2i(IN_X1);
      fy0 = lsu_f2i(SCALED_Y0);
      fy1 = lsu_f2i(SCALED_Y1);
      x = FLOAT_MODE ? $signed(fx[32:0]) : 33'($signed(IN_X));
      x0 = FLOAT_MODE ? $signed(fx0[32:0]) : 33'($signed(IN_X0));
      x1 = FLOAT_MODE ? $signed(fx1[32:0]) : 33'($signed(IN_X1));
      y0 = FLOAT_MODE ? $signed(fy0[32:0]) : 33'($signed(SCALED_Y0));
      y1 = FLOAT_MODE ? $signed(fy1[32:0]) : 33'($signed(SCALED_Y1));
      bad = lsu_bad_float(IN_X) || lsu_bad_float(IN_X0) || lsu_bad_float(IN_X1)
         || lsu_bad_float(SCALED_Y0) || lsu_bad_float(SCALED_Y1);
      cvt_ovf = fx[33] || fx0[33] || fx1[33] || fy0[33] || fy1[33];
      dy = 33'(y1 - y0);
      dx = 33'(x1 - x0);
      dxi = 33'(x - x0);
      // widen before multiplying so the product keeps all its bits
      prod = 66'(dy) * 66'(dxi);
      sprod = 32'($signed(SRC_WORD)) * 32'($signed(RATE));
      trial = {rem_q, num_q[LSU_NUM_W-1]} - {2'b00, den_q};
      q = {1'b0, num_q} + (({rem_q, 1'b0} >= {1'b0, den_q}) ? 67'h1 : 67'h0);
      qs = neg_q ? -68'(q) : 68'(q);
      sum = qs + 68'(addend_q);
      if (op_q == LSU_OP_RATE_OFFSET) begin
         clamped = sum > LSU_WORD_MAX ? 32'(LSU_WORD_MAX) : sum < LSU_WORD_MIN ? 32'(LSU_WORD_MIN) : sum[31:0];
      end else begin
         clamped = sum > LSU_LONG_MAX ? 32'(LSU_LONG_MAX) : sum < LSU_LONG_MIN ? 32'(LSU_LONG_MIN) : sum[31:0];
      end
      case (state_q)
         LSU_IDLE: begin
            if (START && !RUNG_TRUE) begin
               done_d = 1'b1;
            end else if (START) begin
               op_d = OP_SEL;
               flt_d = FLOAT_MODE;
               cnt_d = LSU_CNT_RESET;
               rem_d = 34'h000000000;
               ovf_d = 1'b0;
               if (OP_SEL == LSU_OP_RATE_OFFSET) begin
                  // signed 16-bit rate and offset, magnitude into the divider
                  num_d = LSU_NUM_W'(sprod[31] ? 32'(-sprod) : sprod);
                  den_d = LSU_SCALE_DIVISOR;
                  neg_d = sprod[31];
                  addend_d = 33'($signed(OFFSET));
                  busy_d = 1'b1;
                  state_d = LSU_DIVIDE;
               end else if (FLOAT_MODE && bad) begin
                  done_d = 1'b1;
                  we_d = 1'b1;
                  data_d = LSU_NEG_NAN;
                  ovf_d = 1'b1;
               end else if ((FLOAT_MODE && cvt_ovf) || dy[32] != dy[31] || dx[32] != dx[31]) begin
                  done_d = 1'b1;
                  we_d = 1'b1;
                  data_d = FLOAT_MODE ? LSU_NEG_NAN : LSU_NEG_OVF;
                  ovf_d = 1'b1;
               end else if (dy == 33'sh0 || (dx == 33'sh0 && x == x0)) begin
                  done_d = 1'b1;
                  we_d = 1'b1;
                  data_d = SCALED_Y0;
               end else if (dx == 33'sh0) begin
                  done_d = 1'b1;
                  we_d = 1'b1;
                  data_d = FLOAT_MODE ? LSU_NEG_NAN : LSU_NEG_OVF;
                  ovf_d = 1'b1;
               end else begin
                  // multiply first so the slope keeps its precision
                  num_d = prod[65] ? 66'(-prod) : 66'(prod);
                  den_d = dx[32] ? 33'(-dx) : dx;
                  neg_d = prod[65] ^ dx[32];
                  addend_d = y0;
                  busy_d = 1'b1;
                  state_d = LSU_DIVIDE;
               end
            end
         end
         LSU_DIVIDE: begin
            if (trial[34]) begin
               rem_d = {rem_q[32:0], num_q[LSU_NUM_W-1]};
               num_d = {num_q[LSU_NUM_W-2:0], 1'b0};
            end else begin
               rem_d = trial[33:0];
               num_d = {num_q[LSU_NUM_W-2:0], 1'b1};
            end
            cnt_d = 7'(cnt_q + 7'h01);
            if (cnt_d == LSU_DIV_STEPS) begin
               state_d = LSU_FINISH;
            end
         end
         default: begin
            // round half away from zero, add, saturate, store
            data_d = flt_q ? lsu_i2f(clamped) : clamped;
            ovf_d = 68'($signed(clamped)) != sum;
            we_d = 1'b1;
            done_d = 1'b1;
            busy_d = 1'b0;
            state_d = LSU_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         state_q <= LSU_IDLE;
         num_q <= '0;
         rem_q <= '0;
         den_q <= '0;
         neg_q <= 1'b0;
         addend_q <= '0;
         op_q <= LSU_OP_RATE_OFFSET;
         flt_q <= 1'b0;
         cnt_q <= LSU_CNT_RESET;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         we_q <= 1'b0;
         data_q <= LSU_RESULT_RESET;
         ovf_q <= 1'b0;
      end else begin
         state_q <= state_d;
         num_q <= num_d;
         rem_q <= rem_d;
         den_q <= den_d;
         neg_q <= neg_d;
         addend_q <= addend_d;
         op_q <= op_d;
         flt_q <= flt_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
         we_q <= we_d;
         data_q <= data_d;
         ovf_q <= ovf_d;
      end
   end

   assign BUSY = busy_q;
   assign DONE = done_q;
   assign DEST_WE = we_q;
   assign DEST_DATA = data_q;
   assign OVERFLOW = ovf_q;
endmodule : lsu_scaler

// ==== testbench/lsu_scaler_chk.sv ====
/* Assertions on the linear scaling unit's ports.
   Assumes it is bound into lsu_scaler and sees only that module's ports. */
module lsu_scaler_chk (
   // clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // request
   input wire logic START,
   input wire logic RUNG_TRUE,
   input wire lsu_pkg::lsu_op_t OP_SEL,
   input wire logic FLOAT_MODE,
   input wire logic [31:0] IN_X,
   input wire logic [31:0] IN_X0,
   input wire logic [31:0] IN_X1,
   input wire logic [31:0] SCALED_Y0,
   input wire logic [31:0] SCALED_Y1,
   // answer
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic DEST_WE,
   input wire logic [31:0] DEST_DATA,
   input wire logic OVERFLOW
);
   timeunit 1ns;
   timeprecision 100ps;
   import lsu_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   logic take, ireq;
   logic signed [32:0] span_x, span_y;
   logic spans_fit;
   // a span overflow takes priority over the equal-end and zero-span answers
   assign span_x = 33'($signed(IN_X1)) - 33'($signed(IN_X0));
   assign span_y = 33'($signed(SCALED_Y1)) - 33'($signed(SCALED_Y0));
   assign spans_fit = span_x[32] == span_x[31] && span_y[32] == span_y[31];
   assign take = START && !BUSY;
   assign ireq = take && RUNG_TRUE && OP_SEL == LSU_OP_INTERPOLATE && !FLOAT_MODE;
   sequence s_rate_req; take && RUNG_TRUE && OP_SEL == LSU_OP_RATE_OFFSET; endsequence
   sequence s_rate_run; BUSY [*8] ##60 (DONE && DEST_WE && !BUSY); endsequence
   a_rate_timing: assert property (s_rate_req |=> s_rate_run)
      else $error("rate-offset answer not 68 cycles after start");
   a_rung_false: assert property (take && !RUNG_TRUE |=> DONE && !DEST_WE && $stable(DEST_DATA))
      else $error("rung false request wrote or did not end");
   a_data_hold: assert property (DEST_DATA != $past(DEST_DATA) |-> DEST_WE)
      else $error("result changed without a write");
   a_we_done: assert property (DEST_WE |-> DONE && !BUSY)
      else $error("write strobe outside done");
   a_dy_zero: assert property (ireq && spans_fit && SCALED_Y1 == SCALED_Y0
      |=> DONE && DEST_DATA == $past(SCALED_Y0) && !OVERFLOW)
      else $error("equal scaled ends did not return scaled min");
   a_span_min: assert property (ireq && spans_fit && IN_X1 == IN_X0 && IN_X == IN_X0
      |=> DONE && DEST_DATA == $past(SCALED_Y0))
      else $error("zero span at input min did not return scaled min");
   a_span_err: assert property (ireq && IN_X1 == IN_X0 && IN_X != IN_X0 && SCALED_Y1 != SCALED_Y0
      |=> DEST_DATA == LSU_NEG_OVF && OVERFLOW) else $error("zero span error result wrong");
   a_float_bad: assert property (take && RUNG_TRUE && OP_SEL == LSU_OP_INTERPOLATE && FLOAT_MODE
      && SCALED_Y0[30:23] == LSU_EXP_SPECIAL |=> DEST_WE && DEST_DATA == LSU_NEG_NAN && OVERFLOW)
      else $error("special float operand not answered with negative nan");
endmodule : lsu_scaler_chk

bind lsu_scaler lsu_scaler_chk u_chk (.CLK, .RSTN, .START, .RUNG_TRUE, .OP_SEL, .FLOAT_MODE, .IN_X, .IN_X0,
   .IN_X1, .SCALED_Y0, .SCALED_Y1, .BUSY, .DONE, .DEST_WE, .DEST_DATA, .OVERFLOW);

// ==== testbench/lsu_issuer.sv ====
/* Instruction sequencer model: issues one scaling request and collects the answer.
   Assumes the unit samples operands with START and ends each request with DONE. */
module lsu_issuer (
   // clock
   input wire logic CLK,
   // request
   output logic START,
   output logic RUNG_TRUE,
   output lsu_pkg::lsu_op_t OP_SEL,
   output logic FLOAT_MODE,
   output logic [15:0] SRC_WORD,
   output logic [15:0] RATE,
   output logic [15:0] OFFSET,
   output logic [31:0] IN_X,
   output logic [31:0] IN_X0,
   output logic [31:0] IN_X1,
   output logic [31:0] SCALED_Y0,
   output logic [31:0] SCALED_Y1,
   // answer
   input wire logic DONE,
   input wire logic DEST_WE,
   input wire logic [31:0] DEST_DATA,
   input wire logic OVERFLOW
);
   timeunit 1ns;
   timeprecision 100ps;
   import lsu_pkg::*;
   initial begin
      {START, RUNG_TRUE, FLOAT_MODE} = 3'h0;
      OP_SEL = LSU_OP_RATE_OFFSET;
      {SRC_WORD, RATE, OFFSET, IN_X, IN_X0, IN_X1, SCALED_Y0, SCALED_Y1} = '0;
   end
   // no destination select exists, so the fast counter accumulator is never a target
   task automatic req(input lsu_op_t op, input logic fl, rung, input logic [15:0] s, r, o,
      input logic [31:0] x, x0, x1, y0, y1, output logic dn, we, output logic [31:0] d, output logic ov);
      int n;
      @(posedge CLK);
      #1;
      OP_SEL = op;
      {FLOAT_MODE, RUNG_TRUE, START} = {fl, rung, 1'b1};
      {SRC_WORD, RATE, OFFSET, IN_X, IN_X0, IN_X1, SCALED_Y0, SCALED_Y1} = {s, r, o, x, x0, x1, y0, y1};
      @(posedge CLK);
      #1;
      START = 1'b0;
      // operands only count at START, so scramble them afterwards
      {SRC_WORD, RATE, OFFSET, IN_X, IN_X0, IN_X1, SCALED_Y0, SCALED_Y1} =
         ~{SRC_WORD, RATE, OFFSET, IN_X, IN_X0, IN_X1, SCALED_Y0, SCALED_Y1};
      n = 0;
      while (DONE !== 1'b1 && n < 100) begin
         @(posedge CLK);
         #1;
         n++;
      end
      // done is handed back so a request that never ends counts as a mismatch
      {dn, we, d, ov} = {DONE, DEST_WE, DEST_DATA, OVERFLOW};
   endtask : req
endmodule : lsu_issuer

// ==== testbench/tb.sv ====
/* Self-checking bench for the linear scaling unit, driven through the sequencer model.
   Assumes lsu_pkg, the checker and the sequencer model are compiled first. */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import lsu_pkg::*;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic START, RUNG_TRUE, FLOAT_MODE, BUSY, DONE, DEST_WE, OVERFLOW;
   lsu_op_t OP_SEL;
   logic [15:0] SRC_WORD, RATE, OFFSET;
   logic [31:0] IN_X, IN_X0, IN_X1, SCALED_Y0, SCALED_Y1, DEST_DATA;
   int bad_count = 0;
   int comparisons = 0;
   lsu_scaler u_dut (.CLK, .RSTN, .START, .RUNG_TRUE, .OP_SEL, .FLOAT_MODE, .SRC_WORD, .RATE, .OFFSET, .IN_X,
      .IN_X0, .IN_X1, .SCALED_Y0, .SCALED_Y1, .BUSY, .DONE, .DEST_WE, .DEST_DATA, .OVERFLOW);
   lsu_issuer u_iss (.CLK, .START, .RUNG_TRUE, .OP_SEL, .FLOAT_MODE, .SRC_WORD, .RATE, .OFFSET, .IN_X,
      .IN_X0, .IN_X1, .SCALED_Y0, .SCALED_Y1, .DONE, .DEST_WE, .DEST_DATA, .OVERFLOW);
   always #12.5 CLK = ~CLK;
   task automatic check(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic run(input lsu_op_t op, input logic fl, rung, input logic [15:0] s, r, o,
      input logic [31:0] x, x0, x1, y0, y1, ed, input logic ev);
      logic dn, we, ov;
      logic [31:0] d;
      u_iss.req(op, fl, rung, s, r, o, x, x0, x1, y0, y1, dn, we, d, ov);
      check("done", {31'h0, dn}, 32'h00000001);
      check("write", {31'h0, we}, {31'h0, rung});
      check("data", d, ed);
      check("overflow", {31'h0, ov}, {31'h0, ev});
   endtask : run
   task automatic ip(input logic fl, input logic [31:0] x, x0, x1, y0, y1, ed, input logic ev);
      run(LSU_OP_INTERPOLATE, fl, 1'b1, 16'h0, 16'h0, 16'h0, x, x0, x1, y0, y1, ed, ev);
   endtask : ip
   task automatic rt(input logic signed [15:0] s, r, o);
      longint v;
      logic ev;
      v = longint'(s) * longint'(r);
      v = (v + (v < 0 ? -64'sh1388 : 64'sh1388)) / 64'sh2710 + longint'(o);
      ev = v > 64'sh7FFF || v < -64'sh8000;
      run(LSU_OP_RATE_OFFSET, 1'b0, 1'b1, s, r, o, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
         ev ? (v < 0 ? 32'hFFFF8000 : 32'h7FFF) : v[31:0], ev);
   endtask : rt
   task automatic t_rate();
      rt(16'h64, 16'hFA, 16'h5);
      rt(16'hFF9C, 16'hFA, 16'h0);
      rt(16'h1, 16'h1388, 16'h0);
      rt(16'hFFFF, 16'h1388, 16'h0);
      rt(16'h7FFF, 16'h7FFF, 16'h7FFF);
      rt(16'h8000, 16'h7FFF, 16'h8000);
   endtask : t_rate
   task automatic t_interp();
      ip(1'b0, 32'h5, 32'h0, 32'hA, 32'h64, 32'hC8, 32'h96, 1'b0);
      ip(1'b0, 32'h2, 32'h0, 32'h3, 32'h0, 32'hA, 32'h7, 1'b0);
      ip(1'b1, 32'h40A00000, 32'h0, 32'h41200000, 32'h0, 32'h42C80000, 32'h42480000, 1'b0);
   endtask : t_interp
   task automatic t_special();
      ip(1'b0, 32'h7, 32'h0, 32'h3, 32'h55, 32'h55, 32'h55, 1'b0);
      ip(1'b0, 32'h3, 32'h3, 32'h3, 32'h11, 32'h22, 32'h11, 1'b0);
      ip(1'b0, 32'h4, 32'h3, 32'h3, 32'h11, 32'h22, 32'h80000000, 1'b1);
      ip(1'b1, 32'h40000000, 32'h3F800000, 32'h3F800000, 32'h0, 32'h3F800000, 32'hFFFFFFFF, 1'b1);
      ip(1'b0, 32'h0, 32'h0, 32'h1, 32'h80000000, 32'h7FFFFFFF, 32'h80000000, 1'b1);
      ip(1'b1, 32'h0, 32'h0, 32'h4F800000, 32'h0, 32'h3F800000, 32'hFFFFFFFF, 1'b1);
      ip(1'b1, 32'h0, 32'h0, 32'h3F800000, 32'h7F800000, 32'h0, 32'hFFFFFFFF, 1'b1);
      ip(1'b1, 32'h7FC00000, 32'h0, 32'h3F800000, 32'h0, 32'h3F800000, 32'hFFFFFFFF, 1'b1);
      ip(1'b1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h3F800000, 32'hFFFFFFFF, 1'b1);
   endtask : t_special
   task automatic t_rung();
      ip(1'b0, 32'h7, 32'h0, 32'h3, 32'h55, 32'h55, 32'h55, 1'b0);
      run(LSU_OP_RATE_OFFSET, 1'b0, 1'b0, 16'h64, 16'hFA, 16'h5, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
         32'h55, 1'b0);
      run(LSU_OP_INTERPOLATE, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0, 32'h4, 32'h3, 32'h3, 32'h1, 32'h2,
         32'h55, 1'b0);
   endtask : t_rung
   task automatic finish_test();
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (4000) @(posedge CLK);
      bad_count++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge CLK);
      #1 RSTN = 1'b1;
      t_rate();
      t_interp();
      t_special();
      t_rung();
      finish_test();
   end
endmodule : tb
